//--- audio_source.sv
// Sample source model that drives the link side of the block
`timescale 1ns/1ns
`default_nettype none
module audio_source
    import zero_route_pkg::*;
(
    // Link clock
    input  wire logic                link_clk,
    // Sample outputs
    output logic                     sample_strobe,
    output logic     [SAMPLE_W-1:0]  sample_left,
    output logic     [SAMPLE_W-1:0]  sample_right
);
    initial
    begin
        sample_strobe = 1'b0;
        sample_left   = '0;
        sample_right  = '0;
    end

    // Left and right travel together; released data is scrambled so stale values never match
    task automatic send(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r,
                        input bit more);
        @(posedge link_clk);
        sample_strobe <= 1'b1;
        sample_left   <= l;
        sample_right  <= r;
        if (!more)
        begin
            @(posedge link_clk);
            sample_strobe <= 1'b0;
            sample_left   <= ~l;
            sample_right  <= ~r;
        end
    endtask
endmodule
`default_nettype wire

//--- dac_zero_route.sv
// Zero detection flags, channel routing, phase inversion and gain select
// ----------------------------------------
// Overview of operation
// - Flag each channel after 8192 zero samples
// - Polarity bit chooses flag active level
// - Nonzero sample drops the flag at once
// - Soft reset low holds both flags detected
// - After soft reset, release 4-5 samples later
// - Combined mode flags only when both zero
// - Enable low holds flags at inactive level
// - Stream volume bypass disables zero detection
// - Mono and swap bits select channel routing
// - Invert bits negate each routed output independently
// - Routing identical for every input format
// - Pin mode: straight, right invert pin
// - Gain code decoded per input format
// - Gain pin acts in pulse-code mode only
// ----------------------------------------
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module dac_zero_route
    import zero_route_pkg::*;
#(
    parameter int RUN_LEN = ZERO_RUN_LEN
)
(
    // System clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 soft_reset_n,
    // Register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DATA_W-1:0]    reg_rdata,
    // Control pins
    input  wire logic                 pin_control_mode,
    input  wire logic                 right_phase_invert_pin,
    input  wire logic                 gain_pin,
    output logic      [1:0]           gain_level,
    output logic                      stream_filter_select,
    // Sample link
    input  wire logic                 link_clk,
    input  wire logic                 sample_strobe,
    input  wire logic [SAMPLE_W-1:0]  sample_left,
    input  wire logic [SAMPLE_W-1:0]  sample_right,
    output logic                      out_strobe,
    output logic      [SAMPLE_W-1:0]  out_left,
    output logic      [SAMPLE_W-1:0]  out_right,
    // Zero flag pins
    output logic                      zero_flag_left,
    output logic                      zero_flag_right
);
    // ----------------------------------------
    // Reset release per domain
    // ----------------------------------------
    logic sys_rst_meta;
    logic sys_rst_n;
    logic link_rst_meta;
    logic link_rst_n;

    always_ff @(posedge sys_clk or negedge soft_reset_n)
    begin
        if (!soft_reset_n)
            {sys_rst_n, sys_rst_meta} <= 2'h0;
        else
            {sys_rst_n, sys_rst_meta} <= {sys_rst_meta, 1'h1};
    end

    always_ff @(posedge link_clk or negedge soft_reset_n)
    begin
        if (!soft_reset_n)
            {link_rst_n, link_rst_meta} <= 2'h0;
        else
            {link_rst_n, link_rst_meta} <= {link_rst_meta, 1'h1};
    end

    // ----------------------------------------
    // System domain: registers and gain
    // ----------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] mode;
        logic [DATA_W-1:0] rdata;
        logic [2:0]        pin_meta;
        logic [2:0]        pin_sync;
        logic [1:0]        flag_meta;
        logic [1:0]        flag_sync;
        level_type         gain_level;
        cfg_type           cfg;
    } sys_state_type;

    localparam sys_state_type SYS_RST = '{ctrl: CTRL_RST, mode: MODE_RST,
                                          gain_level: LVL_2V8, default: '0};

    sys_state_type sq;
    sys_state_type sd;
    fmt_type       fmt;
    logic          pin_mode;
    logic          pin_inv_r;
    logic          pin_gain;

    typedef struct packed {
        cfg_type           cfg_meta;
        cfg_type           cfg_sync;
        logic              out_strobe;
        logic [SAMPLE_W-1:0] out_left;
        logic [SAMPLE_W-1:0] out_right;
        logic              flag_l;
        logic              flag_r;
    } link_state_type;

    link_state_type lq;
    link_state_type ld;

    assign fmt       = fmt_type'(sq.mode[MODE_FMT +: FMT_W]);
    assign pin_mode  = sq.pin_sync[0];
    assign pin_inv_r = sq.pin_sync[1];
    assign pin_gain  = sq.pin_sync[2];

    always_comb
    begin
        sd = sq;
        sd.pin_meta  = {gain_pin, right_phase_invert_pin, pin_control_mode};
        sd.pin_sync  = sq.pin_meta;
        sd.flag_meta = {lq.flag_r, lq.flag_l};
        sd.flag_sync = sq.flag_meta;
        // Read data live for one cycle only, zero otherwise
        sd.rdata = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CTRL:   sd.rdata = sq.ctrl;
                REG_MODE:   sd.rdata = sq.mode;
                REG_STATUS:
                begin
                    sd.rdata[STAT_FLAG_L]       = sq.flag_sync[0];
                    sd.rdata[STAT_FLAG_R]       = sq.flag_sync[1];
                    sd.rdata[STAT_LEVEL +: 2]   = sq.gain_level;
                    sd.rdata[STAT_PIN_MODE]     = pin_mode;
                end
                default:    sd.rdata = '0;
            endcase
        end
        if (reg_wr)
        begin
            unique case (reg_addr)
                REG_CTRL: sd.ctrl = reg_wdata;
                REG_MODE: sd.mode = reg_wdata;
                default:  sd.ctrl = sq.ctrl;
            endcase
        end
        // Gain pin only counts in pulse-code mode under pin control
        if (pin_mode && fmt == FMT_PCM)
            sd.gain_level = pin_gain ? LVL_3V75 : LVL_2V8;
        else
            sd.gain_level = gain_decode(fmt, sq.mode[MODE_BYPASS],
                                        sq.mode[MODE_GAIN +: GAIN_W]);
        sd.cfg.enable     = sq.ctrl[CTRL_ENABLE];
        sd.cfg.polarity   = sq.ctrl[CTRL_POLARITY];
        sd.cfg.combined   = sq.ctrl[CTRL_COMBINED];
        sd.cfg.soft_rst_n = sq.ctrl[CTRL_SOFT_RST];
        sd.cfg.mono       = sq.ctrl[CTRL_MONO];
        sd.cfg.swap       = sq.ctrl[CTRL_SWAP];
        sd.cfg.inv_l      = sq.ctrl[CTRL_INV_L];
        sd.cfg.inv_r      = sq.ctrl[CTRL_INV_R];
        sd.cfg.pin_mode   = pin_mode;
        sd.cfg.pin_inv_r  = pin_inv_r;
        sd.cfg.bypass     = (fmt == FMT_STREAM) && sq.mode[MODE_BYPASS];
    end

    always_ff @(posedge sys_clk or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
            sq <= SYS_RST;
        else
            sq <= sd;
    end

    assign reg_rdata            = sq.rdata;
    assign gain_level           = sq.gain_level;
    // Software must keep this clear at gain code 100 on the stream path
    assign stream_filter_select = sq.mode[MODE_FILTER];

    // ----------------------------------------
    // Link domain: detection and routing
    // ----------------------------------------
    // Configuration is quasi-static; a bit that changes mid-sync may take
    // effect one sample later than its neighbours, which is harmless here.
    zero_run_if zl ();
    zero_run_if zr ();

    zero_run_counter #(.RUN_LEN(RUN_LEN)) u_run_left
    (
        .clk   (link_clk),
        .rst_n (link_rst_n),
        .zr    (zl.counter)
    );

    zero_run_counter #(.RUN_LEN(RUN_LEN)) u_run_right
    (
        .clk   (link_clk),
        .rst_n (link_rst_n),
        .zr    (zr.counter)
    );

    cfg_type             cfg;
    logic                det_on;
    logic                act_l;
    logic                act_r;
    logic [SAMPLE_W-1:0] src_l;
    logic [SAMPLE_W-1:0] src_r;
    logic                neg_l;
    logic                neg_r;

    assign cfg       = lq.cfg_sync;
    assign zl.strobe = sample_strobe;
    assign zr.strobe = sample_strobe;
    assign zl.zero   = (sample_left == '0);
    assign zr.zero   = (sample_right == '0);
    assign zl.hold   = !cfg.soft_rst_n;
    assign zr.hold   = !cfg.soft_rst_n;

    always_comb
    begin
        ld = lq;
        ld.cfg_meta = sq.cfg;
        ld.cfg_sync = lq.cfg_meta;
        det_on = cfg.enable && !cfg.bypass;
        act_l  = cfg.combined ? (zl.detect && zr.detect) : zl.detect;
        act_r  = cfg.combined ? (zl.detect && zr.detect) : zr.detect;
        ld.flag_l = (det_on && act_l) ^ cfg.polarity;
        ld.flag_r = (det_on && act_r) ^ cfg.polarity;
        // Format plays no part in routing
        if (cfg.pin_mode)
        begin
            src_l = sample_left;
            src_r = sample_right;
            neg_l = 1'h0;
            neg_r = cfg.pin_inv_r;
        end
        else
        begin
            if (cfg.mono)
            begin
                src_l = cfg.swap ? sample_right : sample_left;
                src_r = src_l;
            end
            else
            begin
                src_l = cfg.swap ? sample_right : sample_left;
                src_r = cfg.swap ? sample_left : sample_right;
            end
            neg_l = cfg.inv_l;
            neg_r = cfg.inv_r;
        end
        ld.out_strobe = sample_strobe;
        if (sample_strobe)
        begin
            ld.out_left  = neg_l ? negate_sat(src_l) : src_l;
            ld.out_right = neg_r ? negate_sat(src_r) : src_r;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            lq <= '0;
        else
            lq <= ld;
    end

    assign out_strobe      = lq.out_strobe;
    assign out_left        = lq.out_left;
    assign out_right       = lq.out_right;
    assign zero_flag_left  = lq.flag_l;
    assign zero_flag_right = lq.flag_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_polarity_level: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        cfg.enable && !cfg.bypass && !cfg.combined && zl.detect
        |=> zero_flag_left == !$past(cfg.polarity))
        else $error("flag level does not follow polarity");
    a_combined_pair: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        cfg.combined |=> zero_flag_left == zero_flag_right)
        else $error("combined flags differ");
    a_disable_idle: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        !cfg.enable |=> zero_flag_left == $past(cfg.polarity)
                     && zero_flag_right == $past(cfg.polarity))
        else $error("disabled flags not inactive");
    a_bypass_idle: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        cfg.bypass |=> zero_flag_right == $past(cfg.polarity))
        else $error("flag active under volume bypass");
    a_route_swap: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        sample_strobe && !cfg.pin_mode && !cfg.mono && cfg.swap && !cfg.inv_r
        |=> out_right == $past(sample_left))
        else $error("swapped routing wrong");
    a_invert_left: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        sample_strobe && !cfg.pin_mode && !cfg.swap && cfg.inv_l
        |=> out_left == negate_sat($past(sample_left)))
        else $error("left inversion wrong");
    a_pin_straight: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        sample_strobe && cfg.pin_mode |=> out_left == $past(sample_left))
        else $error("pin mode left output not straight");
    a_gain_pin: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
        pin_mode && fmt == FMT_PCM && pin_gain |=> gain_level == LVL_3V75)
        else $error("gain pin ignored in pulse-code mode");
    a_gain_stream: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
        fmt == FMT_STREAM && !sq.mode[MODE_BYPASS]
        && sq.mode[MODE_GAIN +: GAIN_W] == GAIN_CODE_HI |=> gain_level == LVL_3V75)
        else $error("stream gain code decode wrong");
    c_flag_rise: cover property (@(posedge link_clk) $rose(zero_flag_left));
    c_mono_route: cover property (@(posedge link_clk)
        sample_strobe && cfg.mono && !cfg.pin_mode);
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for zero flags, routing, inversion and gain select
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench
    import zero_route_pkg::*;
;
    localparam int RUN = 16;
    logic                sys_clk, soft_reset_n, link_clk, reg_wr, reg_rd;
    logic                pin_mode, pin_inv, gain_pin, filt_sel;
    logic                strobe, out_strobe, flag_l, flag_r;
    logic [ADDR_W-1:0]   reg_addr;
    logic [DATA_W-1:0]   reg_wdata, reg_rdata;
    logic [1:0]          gain_level;
    logic [SAMPLE_W-1:0] s_l, s_r, o_l, o_r;
    logic [63:0]         exp_q[$];
    logic [63:0]         exp_v;
    logic [31:0]         rng;
    bit                  mono, swap, il, ir;
    int                  err_count, checked;

    // ----------------------------------------
    // Clocks, model and design
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever
        begin
            #62 link_clk = 1'b1;
            #63 link_clk = 1'b0;
        end
    end

    audio_source i_src (.link_clk(link_clk), .sample_strobe(strobe),
                        .sample_left(s_l), .sample_right(s_r));

    dac_zero_route #(.RUN_LEN(RUN)) i_dut (
        .sys_clk(sys_clk), .soft_reset_n(soft_reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_control_mode(pin_mode), .right_phase_invert_pin(pin_inv),
        .gain_pin(gain_pin), .gain_level(gain_level), .stream_filter_select(filt_sel),
        .link_clk(link_clk), .sample_strobe(strobe), .sample_left(s_l),
        .sample_right(s_r), .out_strobe(out_strobe), .out_left(o_l), .out_right(o_r),
        .zero_flag_left(flag_l), .zero_flag_right(flag_r));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic logic [31:0] neg(logic [31:0] x);
        return (x == 32'h80000000) ? 32'h7FFFFFFF : -x;
    endfunction

    task automatic tally_and_finish();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // Config crosses as a quasi-static vector, so let it settle before traffic
    task automatic cfg(input logic [DATA_W-1:0] c);
        wr(REG_CTRL, c);
        repeat (6) @(posedge link_clk);
    endtask

    task automatic snd(input logic [31:0] l, input logic [31:0] r, input bit more);
        logic [31:0] a, b;
        a = swap ? r : l;
        b = mono ? a : (swap ? l : r);
        if (pin_mode)
        begin
            a = l;
            b = pin_inv ? neg(r) : r;
        end
        else
        begin
            a = il ? neg(a) : a;
            b = ir ? neg(b) : b;
        end
        exp_q.push_back({a, b});
        i_src.send(l, r, more);
    endtask

    task automatic zr(input int n, input logic [31:0] l, input logic [31:0] r);
        for (int i = 0; i < n; i++)
            snd(l, r, i < n - 1);
    endtask

    task automatic fl(input logic el, input logic er);
        repeat (3) @(posedge link_clk);
        #1;
        `CHK(flag_l, el)
        `CHK(flag_r, er)
    endtask

    // ----------------------------------------
    // Output watcher
    // ----------------------------------------
    always @(posedge link_clk)
        if (out_strobe === 1'b1)
        begin
            if (exp_q.size() == 0)
                `CHK(1'b1, 1'b0)
            else
            begin
                exp_v = exp_q.pop_front();
                `CHK({o_l, o_r}, exp_v)
            end
        end

    initial
    begin
        repeat (90000) @(posedge sys_clk);
        $display("[ERR] %0t wait limit ran out", $time);
        err_count++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {soft_reset_n, reg_wr, reg_rd, pin_mode, pin_inv, gain_pin} = 6'h00;
        {reg_addr, reg_wdata} = '0;
        rng = 32'd63141;
        err_count = 0;
        checked = 0;
        repeat (4) @(posedge sys_clk);
        soft_reset_n <= 1'b1;
        repeat (8) @(posedge link_clk);
        rd(REG_CTRL, CTRL_RST);
        rd(REG_MODE, MODE_RST);
        rd(4'hF, 8'h00);
        for (int f = 0; f < 3; f++)
        begin
            wr(REG_MODE, 8'(f));
            for (int c = 0; c < 16; c++)
            begin
                {ir, il, swap, mono} = 4'(c);
                cfg({4'(c), 4'h9});
                snd(xs(), xs(), 1'b1);
                snd(32'h80000000, xs(), 1'b0);
            end
        end
        cfg(8'h79);
        for (int p = 0; p < 2; p++)
        begin
            pin_mode <= 1'b1;
            pin_inv  <= p[0];
            repeat (8) @(posedge link_clk);
            snd(xs(), 32'h80000000, 1'b0);
        end
        for (int f = 0; f < 3; f++)
            for (int b = 0; b < 2; b++)
                for (int g = 0; g < 8; g++)
                begin
                    // Filter bit follows code bit 1, so it is clear at code 100
                    wr(REG_MODE, {1'b0, 3'(g), g[1], b[0], 2'(f)});
                    gain_pin <= g[0];
                    repeat (5) @(posedge sys_clk);
                    `CHK(filt_sel, g[1])
                    if (f == 0)
                        `CHK(gain_level, g[0] ? 2'h2 : 2'h1)
                    else if (f == 1 && b == 0 && (g == 0 || g == 4))
                        `CHK(gain_level, (g == 4) ? 2'h2 : 2'h1)
                    else
                        `CHK(gain_level, 2'h0)
                end
        pin_mode <= 1'b0;
        wr(REG_MODE, 8'h00);
        {ir, il, swap, mono} = 4'h0;
        for (int g = 0; g < 8; g++)
        begin
            wr(REG_MODE, {1'b0, 3'(g), 4'h0});
            repeat (5) @(posedge sys_clk);
            `CHK(gain_level, (g[2:1] == 0) ? 2'h1 : (g[2:1] == 2) ? 2'h2 : 2'h0)
        end
        wr(REG_MODE, 8'h00);
        cfg(8'h09);
        zr(RUN - 1, 0, 0);
        fl(0, 0);
        zr(1, 0, 0);
        fl(1, 1);
        snd(1, 0, 0);
        fl(0, 1);
        cfg(8'h0B);
        fl(1, 0);
        cfg(8'h08);
        fl(0, 0);
        cfg(8'h0A);
        fl(1, 1);
        cfg(8'h0D);
        fl(0, 0);
        zr(RUN, 0, 0);
        fl(1, 1);
        rd(REG_STATUS, 8'h07);
        wr(REG_MODE, 8'h05);
        repeat (6) @(posedge link_clk);
        fl(0, 0);
        wr(REG_MODE, 8'h00);
        snd(1, 1, 0);
        fl(0, 0);
        cfg(8'h01);
        fl(1, 1);
        cfg(8'h09);
        fl(1, 1);
        snd(1, 1, 1);
        zr(3, 5, 5);
        fl(1, 1);
        zr(2, 5, 5);
        fl(0, 0);
        repeat (4) @(posedge link_clk);
        `CHK(exp_q.size(), 0)
        tally_and_finish();
    end
endmodule
`default_nettype wire

//--- zero_route_pkg.sv
// Shared constants, types and helpers for zero detection and channel routing
package zero_route_pkg;

    // ----------------------------------------
    // Sizes and counts
    // ----------------------------------------
    localparam int ZERO_RUN_LEN  = 8192;
    localparam int RELEASE_DELAY = 4;
    localparam int REL_CNT_W     = 3;
    localparam int SAMPLE_W      = 32;
    localparam int ADDR_W        = 4;
    localparam int DATA_W        = 8;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MODE   = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;

    localparam int CTRL_ENABLE   = 0;
    localparam int CTRL_POLARITY = 1;
    localparam int CTRL_COMBINED = 2;
    localparam int CTRL_SOFT_RST = 3;
    localparam int CTRL_MONO     = 4;
    localparam int CTRL_SWAP     = 5;
    localparam int CTRL_INV_L    = 6;
    localparam int CTRL_INV_R    = 7;

    localparam int MODE_FMT      = 0;
    localparam int FMT_W         = 2;
    localparam int MODE_BYPASS   = 2;
    localparam int MODE_FILTER   = 3;
    localparam int MODE_GAIN     = 4;
    localparam int GAIN_W        = 3;

    localparam int STAT_FLAG_L   = 0;
    localparam int STAT_FLAG_R   = 1;
    localparam int STAT_LEVEL    = 2;
    localparam int STAT_PIN_MODE = 4;

    localparam logic [DATA_W-1:0] CTRL_RST = 8'h09;
    localparam logic [DATA_W-1:0] MODE_RST = 8'h00;

    localparam logic [GAIN_W-1:0] GAIN_CODE_LO = 3'h0;
    localparam logic [GAIN_W-1:0] GAIN_CODE_HI = 3'h4;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {FMT_PCM, FMT_STREAM, FMT_EXT_FILTER} fmt_type;
    typedef enum logic [1:0] {LVL_2V5, LVL_2V8, LVL_3V75} level_type;

    typedef struct packed {
        logic enable;
        logic polarity;
        logic combined;
        logic soft_rst_n;
        logic mono;
        logic swap;
        logic inv_l;
        logic inv_r;
        logic pin_mode;
        logic pin_inv_r;
        logic bypass;
    } cfg_type;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic level_type gain_decode(fmt_type fmt, logic bypass,
                                              logic [GAIN_W-1:0] code);
        level_type lvl;
        lvl = LVL_2V5;
        if (fmt == FMT_PCM)
        begin
            if (code[2:1] == GAIN_CODE_LO[2:1])
                lvl = LVL_2V8;
            else if (code[2:1] == GAIN_CODE_HI[2:1])
                lvl = LVL_3V75;
        end
        else if (fmt == FMT_STREAM && !bypass)
        begin
            if (code == GAIN_CODE_LO)
                lvl = LVL_2V8;
            else if (code == GAIN_CODE_HI)
                lvl = LVL_3V75;
        end
        return lvl;
    endfunction

    // Saturates so the most negative code cannot wrap onto itself
    function automatic logic [SAMPLE_W-1:0] negate_sat(logic [SAMPLE_W-1:0] x);
        logic [SAMPLE_W-1:0] r;
        r = -x;
        if (x == {1'h1, {(SAMPLE_W-1){1'h0}}})
            r = {1'h0, {(SAMPLE_W-1){1'h1}}};
        return r;
    endfunction

endpackage

//--- zero_run_counter.sv
// Per-channel zero-run counter with soft-reset hold and delayed release
`timescale 1ns/1ns
`default_nettype none
module zero_run_counter
    import zero_route_pkg::*;
#(
    parameter int RUN_LEN = ZERO_RUN_LEN
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Channel handshake
    zero_run_if.counter      zr
);
    localparam int CW = $clog2(RUN_LEN + 1);
    localparam logic [CW-1:0]        RUN_END = CW'(RUN_LEN);
    localparam logic [REL_CNT_W-1:0] REL_END = REL_CNT_W'(RELEASE_DELAY - 1);

    typedef struct packed {
        logic [CW-1:0]        run_cnt;
        logic                 hold;
        logic                 releasing;
        logic [REL_CNT_W-1:0] rel_cnt;
    } run_state_type;

    run_state_type q;
    run_state_type d;

    // ----------------------------------------
    // Counting
    // ----------------------------------------
    always_comb
    begin
        d = q;
        if (zr.strobe)
        begin
            if (zr.zero && q.run_cnt != RUN_END)
                d.run_cnt = q.run_cnt + CW'(1);
            else if (!zr.zero)
                d.run_cnt = '0;
            if (q.releasing)
            begin
                d.rel_cnt = q.rel_cnt + REL_CNT_W'(1);
                if (q.rel_cnt == REL_END)
                begin
                    d.hold      = 1'h0;
                    d.releasing = 1'h0;
                end
            end
            else if (q.hold && !zr.zero)
            begin
                d.releasing = 1'h1;
                d.rel_cnt   = '0;
            end
        end
        if (zr.hold)
        begin
            d.hold      = 1'h1;
            d.releasing = 1'h0;
            d.rel_cnt   = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    assign zr.run_full = (q.run_cnt == RUN_END);
    assign zr.detect   = zr.run_full | q.hold;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_run_flag_set: assert property (
        zr.strobe && zr.zero && q.run_cnt == RUN_END - CW'(1) |=> zr.run_full)
        else $error("zero run did not flag at full length");
    a_nonzero_clear: assert property (
        zr.strobe && !zr.zero |=> !zr.run_full)
        else $error("zero run flag kept after nonzero sample");
    a_hold_detect: assert property (
        zr.hold |=> zr.detect)
        else $error("detect not held during soft reset");
    a_release_delay: assert property (
        $fell(q.hold) |-> $past(q.rel_cnt) == REL_END && $past(q.releasing))
        else $error("hold released at wrong sample count");
    c_release: cover property ($fell(q.hold));
    c_run_full: cover property ($rose(zr.run_full));
endmodule
`default_nettype wire

//--- zero_run_if.sv
// Handshake between the link logic and one channel's zero-run counter
`timescale 1ns/1ns
`default_nettype none
interface zero_run_if;
    logic strobe;
    logic zero;
    logic hold;
    logic run_full;
    logic detect;

    modport counter (input strobe, input zero, input hold, output run_full, output detect);
    modport user    (output strobe, output zero, output hold, input run_full, input detect);
endinterface
`default_nettype wire
